/* rtl/swing_length_pkg.sv */
// Constants, register map and state types for the swing and length count unit
// Operation
// - Output frequency swings symmetrically about centre
// - Base select 0: amplitude follows set frequency
// - Base select 1: amplitude fixed from maximum
// - Centre mode amplitude is set frequency times ratio
// - Maximum mode amplitude is maximum times ratio
// - Jump step is amplitude times jump ratio
// - Swing frequency clamped between lower, upper limits
// - One swing cycle lasts the programmed period
// - Rise lasts period times coefficient, fall remainder
// - Length is pulses divided by pulses per metre
// - Length reached output when length exceeds target
// - Length reset input clears measured length
// - Length pulse input advances the pulse accumulator
// - Count pulse input advances the event counter
// - Target count reached output, then counting halts
// - Designated count reached output, counting continues
package swing_length_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_PER_PERIOD_UNIT = 100;
	localparam int REG_AW = 5;
	localparam int REG_DW = 16;
	// Register indices
	localparam logic [4:0] OFS_SWING_BASE_SELECT = 5'h00;
	localparam logic [4:0] OFS_SWING_AMPLITUDE_RATIO = 5'h01;
	localparam logic [4:0] OFS_JUMP_AMPLITUDE_RATIO = 5'h02;
	localparam logic [4:0] OFS_SWING_CYCLE_PERIOD = 5'h03;
	localparam logic [4:0] OFS_RISE_TIME_COEFFICIENT = 5'h04;
	localparam logic [4:0] OFS_TARGET_LENGTH = 5'h05;
	localparam logic [4:0] OFS_MEASURED_LENGTH = 5'h06;
	localparam logic [4:0] OFS_PULSES_PER_METRE = 5'h07;
	localparam logic [4:0] OFS_TARGET_COUNT = 5'h08;
	localparam logic [4:0] OFS_DESIGNATED_COUNT = 5'h09;
	localparam logic [4:0] OFS_SET_FREQUENCY = 5'h0a;
	localparam logic [4:0] OFS_MAX_OUTPUT_FREQUENCY = 5'h0b;
	localparam logic [4:0] OFS_UPPER_LIMIT = 5'h0c;
	localparam logic [4:0] OFS_LOWER_LIMIT = 5'h0d;
	localparam logic [4:0] OFS_CONTROL = 5'h0e;
	localparam logic [4:0] OFS_STATUS = 5'h0f;
	localparam logic [4:0] OFS_COUNT_VALUE = 5'h10;
	localparam logic [4:0] OFS_SWING_FREQUENCY = 5'h11;
	// Field positions
	localparam int CTRL_SWING_EN = 0;
	localparam int CTRL_COUNT_CLR = 1;
	localparam int STAT_LEN_REACHED = 0;
	localparam int STAT_CNT_REACHED = 1;
	localparam int STAT_DES_REACHED = 2;
	// Values after reset and limits (ratios in 0.1 %, period in 0.1 s, ppm in 0.1)
	localparam logic [15:0] RST_BASE_SELECT = 16'h0000;
	localparam logic [15:0] RST_SWING_RATIO = 16'h0000;
	localparam logic [15:0] RST_JUMP_RATIO = 16'h0000;
	localparam logic [15:0] RST_PERIOD = 16'h0064;
	localparam logic [15:0] RST_RISE_COEF = 16'h01f4;
	localparam logic [15:0] RST_TARGET_LENGTH = 16'h03e8;
	localparam logic [15:0] RST_PPM = 16'h03e8;
	localparam logic [15:0] RST_TARGET_COUNT = 16'h03e8;
	localparam logic [15:0] RST_DESIGNATED_COUNT = 16'h03e8;
	localparam logic [15:0] RST_SET_FREQUENCY = 16'h0000;
	localparam logic [15:0] RST_MAX_FREQUENCY = 16'h1388;
	localparam logic [15:0] RST_UPPER_LIMIT = 16'h1388;
	localparam logic [15:0] RST_LOWER_LIMIT = 16'h0000;
	localparam logic [15:0] RATIO_FULL = 16'h03e8;
	localparam logic [15:0] JUMP_RATIO_MAX = 16'h01f4;
	localparam logic [15:0] PERIOD_MIN = 16'h0001;
	localparam logic [15:0] PERIOD_MAX = 16'h7530;
	localparam logic [15:0] RISE_COEF_MIN = 16'h0001;
	localparam logic [15:0] PPM_MIN = 16'h0001;
	localparam logic [15:0] COUNT_MIN = 16'h0001;
	localparam logic [3:0] LEN_SCALE = 4'ha;

	typedef struct packed {
		logic [15:0] base_select;
		logic [15:0] swing_ratio;
		logic [15:0] jump_ratio;
		logic [15:0] period;
		logic [15:0] rise_coef;
		logic [15:0] target_length;
		logic [15:0] ppm;
		logic [15:0] target_count;
		logic [15:0] designated_count;
		logic [15:0] set_freq;
		logic [15:0] max_freq;
		logic [15:0] upper_limit;
		logic [15:0] lower_limit;
		logic swing_en;
	} cfg_t;

	typedef struct packed {
		cfg_t cfg;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] sync3;
		logic [15:0] tick_cnt;
		logic [21:0] phase_ms;
		logic [31:0] pulses;
		logic [15:0] count;
		logic length_reached;
		logic count_reached;
		logic designated_reached;
		logic [15:0] swing_freq;
		logic [15:0] rd_data;
	} state_t;
endpackage : swing_length_pkg

/* rtl/swing_length_count_unit.sv */
// Swing frequency generator with length and event pulse counters
`timescale 1ns/1ps
`default_nettype none
module swing_length_count_unit
	import swing_length_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic [4:0] addr, // Register index
	input wire logic [15:0] wr_data, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [15:0] rd_data, // Read data, cycle after strobe
	input wire logic length_pulse_in, // Length count input terminal
	input wire logic length_reset_in, // Length reset input terminal
	input wire logic count_pulse_in, // Counter input terminal
	output logic length_reached, // Length reached terminal
	output logic count_reached, // Target count reached terminal
	output logic designated_reached, // Designated count reached terminal
	output logic [15:0] swing_frequency // Swinging output frequency, 0.01 Hz
);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES_P - 1);
	localparam logic [21:0] MS_UNIT = 22'(MS_PER_PERIOD_UNIT);

	state_t st;
	state_t next_st;

	// Value scaled by a ratio in tenths of a percent
	function automatic logic [15:0] scale_ratio(input logic [15:0] value, input logic [15:0] ratio);
		logic [31:0] prod;
		prod = 32'(value) * 32'(ratio);
		return 16'(prod / 32'(RATIO_FULL));
	endfunction : scale_ratio

	// Limit a register value to a range
	function automatic logic [15:0] limit16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : limit16

	logic [2:0] edge_seen;
	logic pulse_len;
	logic pulse_rst;
	logic pulse_cnt;
	logic tick;
	logic [15:0] base_freq;
	logic [15:0] amp;
	logic [15:0] jump;
	logic [21:0] period_ms;
	logic [21:0] rise_ms;
	logic [21:0] fall_ms;
	logic [21:0] phase_inc;
	logic signed [18:0] span;
	logic [39:0] ramp_num;
	logic [21:0] ramp_den;
	logic [21:0] ramp_pos;
	logic signed [18:0] ramp_step;
	logic signed [18:0] offset;
	logic signed [18:0] raw_freq;
	logic [15:0] clamped_freq;
	logic [35:0] len_num;
	logic [35:0] len_full;
	logic [15:0] meas_len;
	logic write_meas;
	logic count_clr;

	// Rising edges of the synchronised terminals
	assign edge_seen = st.sync2 & ~st.sync3;
	assign pulse_len = edge_seen[0];
	assign pulse_rst = edge_seen[1];
	assign pulse_cnt = edge_seen[2];
	assign tick = (st.tick_cnt == TICK_LAST);

	// Swing amplitude and jump step
	assign base_freq = (st.cfg.base_select == 16'h0000) ? st.cfg.set_freq : st.cfg.max_freq;
	assign amp = scale_ratio(base_freq, st.cfg.swing_ratio);
	assign jump = scale_ratio(amp, st.cfg.jump_ratio);

	// Ramp timing in milliseconds
	assign period_ms = 22'(st.cfg.period) * MS_UNIT;
	assign rise_ms = 22'((32'(st.cfg.period) * 32'(st.cfg.rise_coef)) / 32'(LEN_SCALE));
	assign fall_ms = period_ms - rise_ms;
	assign phase_inc = st.phase_ms + 22'h000001;

	// Triangle: each ramp starts one jump in from the extreme it reversed at
	assign span = 19'(2 * 19'(amp)) - 19'(jump);
	assign ramp_pos = (st.phase_ms < rise_ms) ? st.phase_ms : (st.phase_ms - rise_ms);
	assign ramp_den = (st.phase_ms < rise_ms) ? rise_ms : fall_ms;
	assign ramp_num = 40'(span) * 40'(ramp_pos);
	assign ramp_step = (ramp_den == 22'h000000) ? 19'sh00000 : 19'(ramp_num / 40'(ramp_den));

	// Offset about the centre, rising then falling
	always_comb begin
		if (!st.cfg.swing_en) begin
			offset = 19'sh00000;
		end else if (st.phase_ms < rise_ms) begin
			offset = -19'(amp) + 19'(jump) + ramp_step;
		end else begin
			offset = 19'(amp) - 19'(jump) - ramp_step;
		end
	end

	// Centre plus offset, held within the frequency limits; signed compare so a dip below zero clamps low
	assign raw_freq = 19'(st.cfg.set_freq) + offset;
	always_comb begin
		if (raw_freq > $signed({3'b000, st.cfg.upper_limit})) begin
			clamped_freq = st.cfg.upper_limit;
		end else if (raw_freq < $signed({3'b000, st.cfg.lower_limit})) begin
			clamped_freq = st.cfg.lower_limit;
		end else begin
			clamped_freq = 16'(raw_freq);
		end
	end

	// Measured length in whole metres, saturating
	assign len_num = 36'(st.pulses) * 36'(LEN_SCALE);
	assign len_full = len_num / 36'(st.cfg.ppm);
	assign meas_len = (len_full > 36'h00000ffff) ? 16'hffff : 16'(len_full);

	assign write_meas = wr_en && (addr == OFS_MEASURED_LENGTH);
	assign count_clr = wr_en && (addr == OFS_CONTROL) && wr_data[CTRL_COUNT_CLR];

	// Next state of the whole block
	always_comb begin
		next_st = st;
		next_st.rd_data = 16'h0000;

		// Two-stage synchronisers, third stage for edge detection
		next_st.sync1 = {count_pulse_in, length_reset_in, length_pulse_in};
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;

		// Millisecond tick divider
		next_st.tick_cnt = tick ? 16'h0000 : (st.tick_cnt + 16'h0001);

		// Swing phase within one cycle
		if (!st.cfg.swing_en) begin
			next_st.phase_ms = 22'h000000;
		end else if (tick) begin
			next_st.phase_ms = (phase_inc >= period_ms) ? 22'h000000 : phase_inc;
		end
		next_st.swing_freq = clamped_freq;

		// Length accumulator: a pulse in the clearing cycle still counts
		if (pulse_rst || write_meas) begin
			next_st.pulses = {31'h00000000, pulse_len};
			next_st.length_reached = 1'b0;
		end else begin
			if (pulse_len && (st.pulses != 32'hffffffff)) begin
				next_st.pulses = st.pulses + 32'h00000001;
			end
			next_st.length_reached = (meas_len > st.cfg.target_length);
		end

		// Event counter halts at the target count
		if (count_clr) begin
			next_st.count = 16'h0000;
		end else if (pulse_cnt && (st.count < st.cfg.target_count)) begin
			next_st.count = st.count + 16'h0001;
		end
		next_st.count_reached = (next_st.count >= st.cfg.target_count);
		next_st.designated_reached = (next_st.count >= st.cfg.designated_count);

		// Register writes, held within the legal settings
		if (wr_en) begin
			if (addr == OFS_SWING_BASE_SELECT) begin
				next_st.cfg.base_select = {15'h0000, wr_data[0]};
			end else if (addr == OFS_SWING_AMPLITUDE_RATIO) begin
				next_st.cfg.swing_ratio = limit16(wr_data, 16'h0000, RATIO_FULL);
			end else if (addr == OFS_JUMP_AMPLITUDE_RATIO) begin
				next_st.cfg.jump_ratio = limit16(wr_data, 16'h0000, JUMP_RATIO_MAX);
			end else if (addr == OFS_SWING_CYCLE_PERIOD) begin
				next_st.cfg.period = limit16(wr_data, PERIOD_MIN, PERIOD_MAX);
			end else if (addr == OFS_RISE_TIME_COEFFICIENT) begin
				next_st.cfg.rise_coef = limit16(wr_data, RISE_COEF_MIN, RATIO_FULL);
			end else if (addr == OFS_TARGET_LENGTH) begin
				next_st.cfg.target_length = wr_data;
			end else if (addr == OFS_PULSES_PER_METRE) begin
				next_st.cfg.ppm = limit16(wr_data, PPM_MIN, 16'hffff);
			end else if (addr == OFS_TARGET_COUNT) begin
				next_st.cfg.target_count = limit16(wr_data, COUNT_MIN, 16'hffff);
			end else if (addr == OFS_DESIGNATED_COUNT) begin
				next_st.cfg.designated_count = limit16(wr_data, COUNT_MIN, 16'hffff);
			end else if (addr == OFS_SET_FREQUENCY) begin
				next_st.cfg.set_freq = wr_data;
			end else if (addr == OFS_MAX_OUTPUT_FREQUENCY) begin
				next_st.cfg.max_freq = wr_data;
			end else if (addr == OFS_UPPER_LIMIT) begin
				next_st.cfg.upper_limit = wr_data;
			end else if (addr == OFS_LOWER_LIMIT) begin
				next_st.cfg.lower_limit = wr_data;
			end else if (addr == OFS_CONTROL) begin
				next_st.cfg.swing_en = wr_data[CTRL_SWING_EN];
			end
		end

		// Register reads, data presented in the following cycle
		if (rd_en) begin
			if (addr == OFS_SWING_BASE_SELECT) begin
				next_st.rd_data = st.cfg.base_select;
			end else if (addr == OFS_SWING_AMPLITUDE_RATIO) begin
				next_st.rd_data = st.cfg.swing_ratio;
			end else if (addr == OFS_JUMP_AMPLITUDE_RATIO) begin
				next_st.rd_data = st.cfg.jump_ratio;
			end else if (addr == OFS_SWING_CYCLE_PERIOD) begin
				next_st.rd_data = st.cfg.period;
			end else if (addr == OFS_RISE_TIME_COEFFICIENT) begin
				next_st.rd_data = st.cfg.rise_coef;
			end else if (addr == OFS_TARGET_LENGTH) begin
				next_st.rd_data = st.cfg.target_length;
			end else if (addr == OFS_MEASURED_LENGTH) begin
				next_st.rd_data = meas_len;
			end else if (addr == OFS_PULSES_PER_METRE) begin
				next_st.rd_data = st.cfg.ppm;
			end else if (addr == OFS_TARGET_COUNT) begin
				next_st.rd_data = st.cfg.target_count;
			end else if (addr == OFS_DESIGNATED_COUNT) begin
				next_st.rd_data = st.cfg.designated_count;
			end else if (addr == OFS_SET_FREQUENCY) begin
				next_st.rd_data = st.cfg.set_freq;
			end else if (addr == OFS_MAX_OUTPUT_FREQUENCY) begin
				next_st.rd_data = st.cfg.max_freq;
			end else if (addr == OFS_UPPER_LIMIT) begin
				next_st.rd_data = st.cfg.upper_limit;
			end else if (addr == OFS_LOWER_LIMIT) begin
				next_st.rd_data = st.cfg.lower_limit;
			end else if (addr == OFS_CONTROL) begin
				next_st.rd_data = {15'h0000, st.cfg.swing_en};
			end else if (addr == OFS_STATUS) begin
				next_st.rd_data = {13'h0000, st.designated_reached, st.count_reached, st.length_reached};
			end else if (addr == OFS_COUNT_VALUE) begin
				next_st.rd_data = st.count;
			end else if (addr == OFS_SWING_FREQUENCY) begin
				next_st.rd_data = st.swing_freq;
			end
		end
	end

	// State register with synchronous reset to defaults
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
			st.cfg.base_select <= RST_BASE_SELECT;
			st.cfg.swing_ratio <= RST_SWING_RATIO;
			st.cfg.jump_ratio <= RST_JUMP_RATIO;
			st.cfg.period <= RST_PERIOD;
			st.cfg.rise_coef <= RST_RISE_COEF;
			st.cfg.target_length <= RST_TARGET_LENGTH;
			st.cfg.ppm <= RST_PPM;
			st.cfg.target_count <= RST_TARGET_COUNT;
			st.cfg.designated_count <= RST_DESIGNATED_COUNT;
			st.cfg.set_freq <= RST_SET_FREQUENCY;
			st.cfg.max_freq <= RST_MAX_FREQUENCY;
			st.cfg.upper_limit <= RST_UPPER_LIMIT;
			st.cfg.lower_limit <= RST_LOWER_LIMIT;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign rd_data = st.rd_data;
	assign length_reached = st.length_reached;
	assign count_reached = st.count_reached;
	assign designated_reached = st.designated_reached;
	assign swing_frequency = st.swing_freq;
endmodule : swing_length_count_unit
`default_nettype wire

/* verif/swing_length_count_unit_monitor.sv */
// Port checker for the swing and length count unit
`timescale 1ns/1ps
`default_nettype none
module swing_length_count_unit_monitor
	import swing_length_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic sys_clk, // Clock
	input wire logic srst, // Reset
	input wire logic [4:0] addr, // Index
	input wire logic [15:0] wr_data, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	input wire logic [15:0] rd_data, // Read data
	input wire logic length_pulse_in, // Length pin
	input wire logic length_reset_in, // Clear pin
	input wire logic count_pulse_in, // Count pin
	input wire logic length_reached, // Length flag
	input wire logic count_reached, // Target flag
	input wire logic designated_reached, // Designated flag
	input wire logic [15:0] swing_frequency // Swing output
);
	logic [15:0] upper_h;
	logic [15:0] lower_h;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// Shadow copies of the frequency limits
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			upper_h <= RST_UPPER_LIMIT;
			lower_h <= RST_LOWER_LIMIT;
		end else if (wr_en) begin
			if (addr == OFS_UPPER_LIMIT) upper_h <= wr_data;
			if (addr == OFS_LOWER_LIMIT) lower_h <= wr_data;
		end
	end
	a_rd_quiet: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
		else $error("read data outside read slot");
	a_upper_clamp: assert property (upper_h == $past(upper_h) |-> swing_frequency <= upper_h)
		else $error("swing above upper limit");
	a_lower_clamp: assert property (lower_h == $past(lower_h) |-> swing_frequency >= lower_h)
		else $error("swing below lower limit");
	a_count_halts: assert property (count_reached && !wr_en && !$past(wr_en) && !$past(wr_en, 2) |=> count_reached)
		else $error("target flag dropped");
	a_designated_first: assert property (count_reached |-> designated_reached)
		else $error("designated flag missing");
	a_count_cause: assert property ($rose(count_reached) |-> $past(count_pulse_in, 3) || $past(wr_en, 2))
		else $error("target flag without pulse");
	a_length_cause: assert property ($rose(length_reached) |-> $past(length_pulse_in, 4) || $past(wr_en, 2))
		else $error("length flag without pulse");
	a_length_clear: assert property ($rose(length_reset_in) |-> ##4 !length_reached)
		else $error("length flag not cleared");
	// Main scenarios reached
	c_count: cover property ($rose(count_reached));
	c_designated: cover property ($rose(designated_reached));
	c_length: cover property ($rose(length_reached));
endmodule : swing_length_count_unit_monitor
bind swing_length_count_unit swing_length_count_unit_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_mon (
	.sys_clk(sys_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .length_pulse_in(length_pulse_in), .length_reset_in(length_reset_in),
	.count_pulse_in(count_pulse_in), .length_reached(length_reached), .count_reached(count_reached),
	.designated_reached(designated_reached), .swing_frequency(swing_frequency));
`default_nettype wire

/* verif/pulse_source_model.sv */
// Pulse source standing in for the input terminals
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
	input wire logic sys_clk, // Clock
	input wire logic srst, // Reset
	input wire logic [2:0] fire, // One-hot request
	input wire logic slow, // Wide pulse
	output logic busy, // Pulse running
	output logic [2:0] pins // Length, clear, count
);
	logic [3:0] left;
	logic [3:0] half;
	// One pulse per request; idle pins sit low like pulled-down terminals
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy <= 1'b0;
			pins <= 3'h0;
			left <= 4'h0;
			half <= 4'h0;
		end else if (!busy && fire != 3'h0) begin
			busy <= 1'b1;
			pins <= fire;
			half <= slow ? 4'h4 : 4'h2;
			left <= slow ? 4'h7 : 4'h3;
		end else if (busy) begin
			left <= left - 4'h1;
			if (left == half) pins <= 3'h0;
			if (left == 4'h0) busy <= 1'b0;
		end
	end
endmodule : pulse_source_model
`default_nettype wire

/* verif/swing_length_count_unit_tb_top.sv */
// Self-checking bench for the swing and length count unit
`timescale 1ns/1ps
`default_nettype none
module swing_length_count_unit_tb_top
	import swing_length_pkg::*;
;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [15:0] wr_data = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [2:0] fire = 3'h0;
	logic slow = 1'b0;
	logic busy;
	logic [2:0] pins;
	logic [15:0] rd_data;
	logic length_reached;
	logic count_reached;
	logic designated_reached;
	logic [15:0] swing_frequency;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed = 32'hc8d5125b;
	int ppm;
	logic [15:0] q;
	logic [15:0] dflt [14] = '{RST_BASE_SELECT, RST_SWING_RATIO, RST_JUMP_RATIO, RST_PERIOD, RST_RISE_COEF,
		RST_TARGET_LENGTH, 16'h0000, RST_PPM, RST_TARGET_COUNT, RST_DESIGNATED_COUNT, RST_SET_FREQUENCY,
		RST_MAX_FREQUENCY, RST_UPPER_LIMIT, RST_LOWER_LIMIT};
	swing_length_count_unit #(.TICK_CYCLES_P(4)) i_swing_length_count_unit (.sys_clk(sys_clk), .srst(srst),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.length_pulse_in(pins[0]), .length_reset_in(pins[1]), .count_pulse_in(pins[2]),
		.length_reached(length_reached), .count_reached(count_reached),
		.designated_reached(designated_reached), .swing_frequency(swing_frequency));
	pulse_source_model i_pulse_source_model (.sys_clk(sys_clk), .srst(srst), .fire(fire), .slow(slow),
		.busy(busy), .pins(pins));
	// Clock and hang guard
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			results;
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (exp !== got) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd
	// One terminal pulse, then the flag latency
	task automatic pulse(input logic [2:0] k);
		int n;
		@(posedge sys_clk);
		fire <= k;
		slow <= 1'($random(seed));
		@(posedge sys_clk);
		fire <= 3'h0;
		#1;
		for (n = 0; n < 20 && busy; n++) @(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
	endtask : pulse
	// Extremes of one swing period of 100 ms, clamped
	function automatic void swing_ext(input int c, b, r, j, cf, up, dn, output int lo, output int hi);
		int amp, jmp, rise, v;
		amp = (b != 0 ? int'(RST_MAX_FREQUENCY) : c) * r / 1000;
		jmp = amp * j / 1000;
		rise = cf / 10;
		lo = 65535;
		hi = 0;
		for (int t = 0; t < 100; t++) begin
			if (t < rise) v = c - amp + jmp + (2 * amp - jmp) * t / rise;
			else v = c + amp - jmp - (2 * amp - jmp) * (t - rise) / (100 - rise);
			if (v > up) v = up;
			if (v < dn) v = dn;
			if (v < lo) lo = v;
			if (v > hi) hi = v;
		end
	endfunction : swing_ext
	task automatic swing_row(input int b, c, r, j, cf, up, dn);
		int mn, mx, e_lo, e_hi;
		wr(OFS_SWING_BASE_SELECT, 16'(b));
		wr(OFS_SET_FREQUENCY, 16'(c));
		wr(OFS_SWING_AMPLITUDE_RATIO, 16'(r));
		wr(OFS_JUMP_AMPLITUDE_RATIO, 16'(j));
		wr(OFS_RISE_TIME_COEFFICIENT, 16'(cf));
		wr(OFS_UPPER_LIMIT, 16'(up));
		wr(OFS_LOWER_LIMIT, 16'(dn));
		repeat (8) @(posedge sys_clk);
		mn = 65535;
		mx = 0;
		for (int n = 0; n < 440; n++) begin
			@(posedge sys_clk);
			#1;
			if (swing_frequency < mn) mn = swing_frequency;
			if (swing_frequency > mx) mx = swing_frequency;
		end
		swing_ext(c, b, r, j, cf, up, dn, e_lo, e_hi);
		check("swing min", 16'(e_lo), 16'(mn));
		check("swing max", 16'(e_hi), 16'(mx));
	endtask : swing_row
	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 14; i++) begin
			rd(5'(i), q);
			check("reset value", dflt[i], q);
		end
		rd(5'h1f, q);
		check("unmapped read", 16'h0000, q);
		wr(OFS_SWING_AMPLITUDE_RATIO, 16'hffff);
		rd(OFS_SWING_AMPLITUDE_RATIO, q);
		check("swing ratio cap", RATIO_FULL, q);
		wr(OFS_JUMP_AMPLITUDE_RATIO, 16'hffff);
		rd(OFS_JUMP_AMPLITUDE_RATIO, q);
		check("jump ratio cap", JUMP_RATIO_MAX, q);
		$display("test registers done");
		wr(OFS_DESIGNATED_COUNT, 16'h0003);
		wr(OFS_TARGET_COUNT, 16'h0005);
		for (int n = 1; n <= 7; n++) begin
			pulse(3'h4);
			rd(OFS_COUNT_VALUE, q);
			check("count", 16'(n > 5 ? 5 : n), q);
			check("count reached", 16'(n >= 5), 16'(count_reached));
			check("designated reached", 16'(n >= 3), 16'(designated_reached));
		end
		rd(OFS_STATUS, q);
		check("status", 16'((1 << STAT_CNT_REACHED) | (1 << STAT_DES_REACHED)), q);
		wr(OFS_CONTROL, 16'h0002);
		rd(OFS_COUNT_VALUE, q);
		check("count cleared", 16'h0000, q);
		$display("test counter done");
		ppm = 5 + ($random(seed) & 15);
		wr(OFS_PULSES_PER_METRE, 16'(ppm));
		wr(OFS_TARGET_LENGTH, 16'h0001);
		for (int n = 1; n <= 5; n++) begin
			pulse(3'h1);
			rd(OFS_MEASURED_LENGTH, q);
			check("length", 16'(n * 10 / ppm), q);
			check("length reached", 16'(n * 10 / ppm > 1), 16'(length_reached));
		end
		pulse(3'h2);
		rd(OFS_MEASURED_LENGTH, q);
		check("length cleared", 16'h0000, q);
		check("length flag cleared", 16'h0000, 16'(length_reached));
		$display("test length done");
		wr(OFS_SWING_CYCLE_PERIOD, 16'h0001);
		wr(OFS_CONTROL, 16'h0001);
		swing_row(0, 1000, 100, 0, 500, 5000, 0);
		swing_row(1, 1000, 100, 0, 500, 5000, 0);
		swing_row(1, 2000, 100, 0, 500, 5000, 0);
		swing_row(0, 2000, 100, 0, 500, 5000, 0);
		swing_row(0, 1000, 100, 500, 500, 5000, 0);
		swing_row(0, 1000, 100, 0, 500, 1050, 0);
		swing_row(1, 200, 100, 0, 500, 5000, 100);
		swing_row(0, 500 + ($random(seed) & 2047), $random(seed) & 511, 0, 100 + ($random(seed) & 511), 5000, 0);
		$display("test swing done");
		results;
	end
endmodule : swing_length_count_unit_tb_top
`default_nettype wire
